// [shared/ettx_pkg.sv]
// Purpose: Constants, layouts and types of the event triggered transfer engine.
// Assumes: Big-endian memory, 32-bit memory words, one clock CLK_SYS at 20 MHz.
// Notes: Overview of operation follows.
// Overview of operation
// - Transfer-mode field 00 in mode word A selects normal transfer mode.
// - Unit-size field 00 in mode word A moves one byte per unit.
// - Source mode 10 increments the source pointer, 00 holds it.
// - Destination mode 10 increments the destination pointer, 00 holds it.
// - Chain enable 0 means no further record is fetched after a transfer.
// - Chain condition 0 chains after every transfer, not only at count end.
// - Interrupt select 0 passes the CPU interrupt request at count end.
// - Area select 0 makes the destination the repeat area.
// - Transfer count gives the number of unit transfers; 20h means 32.
// - Only sources enabled in register E start transfers; bit 10 tx, bit 11 rx.
// - Read skip 0 always re-reads the record on activation.
// - Repeat chain enable 0 blocks chaining in repeat mode.
// - Fault flag 0 means no pending error interrupt request.
// - Vector table addresses are formed from the vector base register.
// - Record holds mode A, mode B, source, destination, count; records 16 bytes apart.
// - Activation reads the vector entry, then the record at that address.
// - Each transfer writes the updated pointers and count back to memory.
// - Normal mode supports counts 1 to 65536, with zero meaning 65536.
package ettx_pkg;
  localparam logic [31:0] ADDR_ENABLE_E = 32'hfffe6008;
  localparam logic [31:0] ADDR_CONTROL = 32'hfffe6010;
  localparam logic [31:0] ADDR_VECTOR_BASE = 32'hfffe6014;
  localparam logic [15:0] RST_ENABLE_E = 16'h0000;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [31:0] RST_VECTOR_BASE = 32'h00000000;
  localparam int CC_FAULT = 0;
  localparam int CC_REPEAT_CHAIN = 1;
  localparam int CC_READ_SKIP = 2;
  localparam int EN_TX_BIT = 10;
  localparam int EN_RX_BIT = 11;
  localparam logic [31:0] VEC_OFS_TX = 32'h00000000;
  localparam logic [31:0] VEC_OFS_RX = 32'h00000004;
  localparam logic [31:0] REC_STRIDE = 32'h00000010;
  localparam logic [31:0] REC_SRC_OFS = 32'h00000004;
  localparam logic [31:0] REC_DST_OFS = 32'h00000008;
  localparam logic [31:0] REC_CNT_OFS = 32'h0000000c;
  localparam int MA_MODE_LSB = 6;
  localparam int MA_SIZE_LSB = 4;
  localparam int MA_SRC_LSB = 2;
  localparam int MB_CHAIN_EN = 7;
  localparam int MB_CHAIN_COND = 6;
  localparam int MB_INT_SEL = 5;
  localparam int MB_AREA_SEL = 4;
  localparam int MB_DST_LSB = 2;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_REPEAT = 2'h1;
  localparam logic [1:0] MODE_BAD = 2'h3;
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_BAD = 2'h3;
  localparam logic [1:0] AM_INC = 2'h2;
  localparam logic [1:0] AM_DEC = 2'h3;

  typedef struct packed {
    logic [7:0] mode_word_a;
    logic [7:0] mode_word_b;
    logic [31:0] source_pointer;
    logic [31:0] dest_pointer;
    logic [15:0] transfer_count;
  } ettx_rec_type;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic rd;
    logic wr;
  } ettx_mem_req_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_VEC = 4'h1,
    ST_REC_RD = 4'h2,
    ST_REC_WT = 4'h3,
    ST_CHECK = 4'h4,
    ST_SRC = 4'h5,
    ST_WB = 4'h6,
    ST_END = 4'h7
  } ettx_state_type;
endpackage

// [verilog/ettx_lane.sv]
// Purpose: Byte lane steering of one unit between a read word and a write word.
// Assumes: Big-endian lanes, lane 0 in bits 31:24.
// Notes: Long units ignore the low address bits.
`timescale 1ns/1ps
module ettx_lane (
  // Unit shape.
  input wire logic [1:0] size,
  input wire logic [1:0] src_lane,
  input wire logic [1:0] dst_lane,
  // Data.
  input wire logic [31:0] rdata,
  output logic [31:0] wdata,
  output logic [3:0] be
);
  import ettx_pkg::*;
  logic [31:0] unit;
  always_comb begin
    unit = rdata;
    wdata = rdata;
    be = 4'hf;
    case (size)
      SIZE_BYTE: begin
        unit = {24'h000000, rdata[(5'd24 - {src_lane, 3'b000}) +: 8]};
        wdata = unit << (5'd24 - {dst_lane, 3'b000});
        be = 4'h8 >> dst_lane;
      end
      SIZE_WORD: begin
        unit = {16'h0000, rdata[(5'd16 - {src_lane[1], 4'h0}) +: 16]};
        wdata = unit << (5'd16 - {dst_lane[1], 4'h0});
        be = dst_lane[1] ? 4'h3 : 4'hc;
      end
      default: begin
        wdata = rdata;
        be = 4'hf;
      end
    endcase
  end
endmodule // ettx_lane

// [verilog/ettx_engine.sv]
// Purpose: Event triggered transfer engine serving serial port requests.
// Assumes: Memory answers every read within the request cycle and takes writes at once.
// Notes: Block mode runs as normal mode.
`timescale 1ns/1ps
module ettx_engine (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Register port.
  input wire logic [31:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // Serial port requests.
  input wire logic TX_EMPTY_REQUEST,
  input wire logic RX_FULL_REQUEST,
  // Memory master.
  output ettx_pkg::ettx_mem_req_type MEM_REQ,
  input wire logic [31:0] MEM_RDATA,
  // Status.
  output logic CPU_IRQ,
  output logic ERR_IRQ,
  output logic BUSY
);
  import ettx_pkg::*;

  ettx_state_type state;
  ettx_rec_type rec;
  ettx_mem_req_type mem;
  logic [15:0] activation_enable_e;
  logic [7:0] controller_control;
  logic [31:0] vector_base;
  logic [31:0] rec_addr;
  logic [31:0] rpt_ptr;
  logic [15:0] rpt_cnt;
  logic [1:0] idx;
  logic src_rx;
  logic last_rx;
  logic cache_ok;
  logic unit_done;
  logic irq;
  logic fault_set;
  logic [15:0] en_clr;
  logic [31:0] rdata;
  logic [31:0] lane_wdata;
  logic [3:0] lane_be;
  logic [1:0] pend;
  logic [1:0] md;
  logic [1:0] sz;
  logic [1:0] sm;
  logic [1:0] dm;
  logic [31:0] step;
  logic [31:0] next_sar;
  logic [31:0] next_dar;
  logic [15:0] next_cnt;
  logic next_done;
  logic chain_go;
  logic vb_wr;

  assign md = rec.mode_word_a[MA_MODE_LSB +: 2];
  assign sz = rec.mode_word_a[MA_SIZE_LSB +: 2];
  assign sm = rec.mode_word_a[MA_SRC_LSB +: 2];
  assign dm = rec.mode_word_b[MB_DST_LSB +: 2];
  assign pend[1] = RX_FULL_REQUEST & activation_enable_e[EN_RX_BIT];
  assign pend[0] = TX_EMPTY_REQUEST & activation_enable_e[EN_TX_BIT];
  assign vb_wr = REG_WR && (REG_ADDR == ADDR_VECTOR_BASE);

  ettx_lane u_lane (
    .size(sz),
    .src_lane(rec.source_pointer[1:0]),
    .dst_lane(rec.dest_pointer[1:0]),
    .rdata(MEM_RDATA),
    .wdata(lane_wdata),
    .be(lane_be)
  );

  // Pointer and count updates for the unit now in flight.
  always_comb begin
    step = 32'h00000001;
    if (sz == SIZE_WORD) begin
      step = 32'h00000002;
    end else if (sz != SIZE_BYTE) begin
      step = 32'h00000004;
    end
    next_sar = rec.source_pointer;
    next_dar = rec.dest_pointer;
    if (sm == AM_INC) begin
      next_sar = rec.source_pointer + step;
    end else if (sm == AM_DEC) begin
      next_sar = rec.source_pointer - step;
    end
    if (dm == AM_INC) begin
      next_dar = rec.dest_pointer + step;
    end else if (dm == AM_DEC) begin
      next_dar = rec.dest_pointer - step;
    end
    next_cnt = rec.transfer_count - 16'h0001;
    next_done = (next_cnt == 16'h0000);
    if (md == MODE_REPEAT && next_done) begin
      next_cnt = rpt_cnt;
      if (rec.mode_word_b[MB_AREA_SEL]) begin
        next_sar = rpt_ptr;
      end else begin
        next_dar = rpt_ptr;
      end
    end
  end

  // Chaining decision after write-back.
  always_comb begin
    chain_go = rec.mode_word_b[MB_CHAIN_EN];
    if (rec.mode_word_b[MB_CHAIN_COND] && !unit_done) begin
      chain_go = 1'b0;
    end
    if (md == MODE_REPEAT && !controller_control[CC_REPEAT_CHAIN]) begin
      chain_go = 1'b0;
    end
  end

  // Transfer sequencer.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      rec <= '0;
      mem <= '0;
      rec_addr <= 32'h00000000;
      rpt_ptr <= 32'h00000000;
      rpt_cnt <= 16'h0000;
      idx <= 2'h0;
      src_rx <= 1'b0;
      last_rx <= 1'b0;
      cache_ok <= 1'b0;
      unit_done <= 1'b0;
      irq <= 1'b0;
      fault_set <= 1'b0;
      en_clr <= 16'h0000;
    end else begin
      mem.rd <= 1'b0;
      mem.wr <= 1'b0;
      irq <= 1'b0;
      fault_set <= 1'b0;
      en_clr <= 16'h0000;
      if (vb_wr) begin
        cache_ok <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (pend != 2'b00) begin
            src_rx <= pend[1];
            if (controller_control[CC_READ_SKIP] && cache_ok && (last_rx == pend[1]) && !vb_wr) begin
              state <= ST_CHECK;
            end else begin
              mem.addr <= vector_base + (pend[1] ? VEC_OFS_RX : VEC_OFS_TX);
              mem.rd <= 1'b1;
              state <= ST_VEC;
            end
          end
        end
        ST_VEC: begin
          rec_addr <= MEM_RDATA;
          idx <= 2'h0;
          state <= ST_REC_RD;
        end
        ST_REC_RD: begin
          mem.addr <= rec_addr + {28'h0000000, idx, 2'b00};
          mem.rd <= 1'b1;
          state <= ST_REC_WT;
        end
        ST_REC_WT: begin
          case (idx)
            2'h0: begin
              rec.mode_word_a <= MEM_RDATA[31:24];
              rec.mode_word_b <= MEM_RDATA[23:16];
            end
            2'h1: begin
              rec.source_pointer <= MEM_RDATA;
            end
            2'h2: begin
              rec.dest_pointer <= MEM_RDATA;
            end
            default: begin
              rec.transfer_count <= MEM_RDATA[31:16];
              rpt_cnt <= MEM_RDATA[31:16];
            end
          endcase
          if (idx == 2'h3) begin
            rpt_ptr <= rec.mode_word_b[MB_AREA_SEL] ? rec.source_pointer : rec.dest_pointer;
            state <= ST_CHECK;
          end else begin
            idx <= idx + 2'h1;
            state <= ST_REC_RD;
          end
        end
        ST_CHECK: begin
          if (md == MODE_BAD || sz == SIZE_BAD) begin
            fault_set <= 1'b1;
            cache_ok <= 1'b0;
            state <= ST_IDLE;
          end else begin
            mem.addr <= {rec.source_pointer[31:2], 2'b00};
            mem.rd <= 1'b1;
            state <= ST_SRC;
          end
        end
        ST_SRC: begin
          mem.addr <= {rec.dest_pointer[31:2], 2'b00};
          mem.wdata <= lane_wdata;
          mem.be <= lane_be;
          mem.wr <= 1'b1;
          rec.source_pointer <= next_sar;
          rec.dest_pointer <= next_dar;
          rec.transfer_count <= next_cnt;
          unit_done <= next_done;
          idx <= 2'h0;
          state <= ST_WB;
        end
        ST_WB: begin
          mem.wr <= 1'b1;
          mem.be <= 4'hf;
          case (idx)
            2'h0: begin
              mem.addr <= rec_addr + REC_SRC_OFS;
              mem.wdata <= rec.source_pointer;
            end
            2'h1: begin
              mem.addr <= rec_addr + REC_DST_OFS;
              mem.wdata <= rec.dest_pointer;
            end
            default: begin
              mem.addr <= rec_addr + REC_CNT_OFS;
              mem.wdata <= {rec.transfer_count, 16'h0000};
              mem.be <= 4'hc;
            end
          endcase
          if (idx == 2'h2) begin
            state <= ST_END;
          end else begin
            idx <= idx + 2'h1;
          end
        end
        ST_END: begin
          if (unit_done && md != MODE_REPEAT) begin
            en_clr[src_rx ? EN_RX_BIT : EN_TX_BIT] <= 1'b1;
          end
          irq <= unit_done | rec.mode_word_b[MB_INT_SEL];
          if (chain_go) begin
            rec_addr <= rec_addr + REC_STRIDE;
            idx <= 2'h0;
            cache_ok <= 1'b0;
            state <= ST_REC_RD;
          end else begin
            last_rx <= src_rx;
            cache_ok <= !vb_wr;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Software registers; hardware set and clear act on top of a write.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      activation_enable_e <= RST_ENABLE_E;
      controller_control <= RST_CONTROL;
      vector_base <= RST_VECTOR_BASE;
    end else begin
      if (REG_WR && REG_ADDR == ADDR_ENABLE_E) begin
        activation_enable_e <= REG_WDATA[15:0] & ~en_clr;
      end else begin
        activation_enable_e <= activation_enable_e & ~en_clr;
      end
      if (REG_WR && REG_ADDR == ADDR_CONTROL) begin
        controller_control <= REG_WDATA[7:0];
        controller_control[CC_FAULT] <= REG_WDATA[CC_FAULT] | fault_set;
      end else begin
        controller_control[CC_FAULT] <= controller_control[CC_FAULT] | fault_set;
      end
      if (vb_wr) begin
        vector_base <= REG_WDATA;
      end
    end
  end

  // Register read data, valid only in the cycle after the strobe.
  always_comb begin
    rdata = 32'h00000000;
    case (REG_ADDR)
      ADDR_ENABLE_E: begin
        rdata = {16'h0000, activation_enable_e};
      end
      ADDR_CONTROL: begin
        rdata = {24'h000000, controller_control};
      end
      ADDR_VECTOR_BASE: begin
        rdata = vector_base;
      end
      default: begin
        rdata = 32'h00000000;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      REG_RDATA <= 32'h00000000;
    end else begin
      REG_RDATA <= REG_RD ? rdata : 32'h00000000;
    end
  end

  assign MEM_REQ = mem;
  assign CPU_IRQ = irq;
  assign ERR_IRQ = controller_control[CC_FAULT];
  assign BUSY = (state != ST_IDLE);
endmodule // ettx_engine

// [verification/ettx_properties.sv]
// Purpose: Port level checks of the transfer engine.
// Assumes: Read skip, interrupt select and chaining stay off.
// Notes: Bound to every engine instance.
`timescale 1ns/1ps
module ettx_properties (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // Register port.
  input wire logic [31:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  // Requests.
  input wire logic TX_EMPTY_REQUEST,
  input wire logic RX_FULL_REQUEST,
  // Memory.
  input wire ettx_pkg::ettx_mem_req_type MEM_REQ,
  input wire logic [31:0] MEM_RDATA,
  // Status.
  input wire logic CPU_IRQ,
  input wire logic ERR_IRQ,
  input wire logic BUSY
);
  import ettx_pkg::*;
  logic [31:0] vbase;
  logic [31:0] rec;
  logic busy_q;
  logic vec_rd;
  logic cnt_wr;
  assign vec_rd = MEM_REQ.rd && !busy_q;
  assign cnt_wr = MEM_REQ.wr && MEM_REQ.addr == rec + REC_CNT_OFS;
  always_ff @(posedge CLK_SYS) begin
    busy_q <= RST_N && BUSY;
  end
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      vbase <= RST_VECTOR_BASE;
    end else if (REG_WR && REG_ADDR == ADDR_VECTOR_BASE) begin
      vbase <= REG_WDATA;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (vec_rd) begin
      rec <= MEM_RDATA;
    end
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_read_data_clear: assert property (!REG_RD |=> REG_RDATA == 32'h0) else $error("read data not cleared");
  a_vector_entry: assert property ($rose(BUSY) |-> vec_rd &&
    (MEM_REQ.addr == vbase + VEC_OFS_TX || MEM_REQ.addr == vbase + VEC_OFS_RX)) else $error("bad vector read");
  a_record_words: assert property (vec_rd |-> ##2 (MEM_REQ.rd && MEM_REQ.addr == rec)
    ##2 (MEM_REQ.rd && MEM_REQ.addr == rec + REC_SRC_OFS) ##2 (MEM_REQ.rd && MEM_REQ.addr == rec + REC_DST_OFS)
    ##2 (MEM_REQ.rd && MEM_REQ.addr == rec + REC_CNT_OFS)) else $error("bad record reads");
  a_count_lanes: assert property (cnt_wr |-> MEM_REQ.be == 4'hc) else $error("bad count lanes");
  a_writeback_order: assert property (MEM_REQ.wr && MEM_REQ.addr == rec + REC_SRC_OFS |=>
    (MEM_REQ.wr && MEM_REQ.addr == rec + REC_DST_OFS) ##1 cnt_wr) else $error("bad write back order");
  a_irq_at_end: assert property (cnt_wr && MEM_REQ.wdata[31:16] == 16'h0 |-> ##1 CPU_IRQ)
    else $error("missing end interrupt");
  a_irq_midway: assert property (cnt_wr && MEM_REQ.wdata[31:16] != 16'h0 |-> ##1 (!CPU_IRQ) [*2])
    else $error("early interrupt");
  a_no_chain: assert property (cnt_wr |=> !BUSY && !MEM_REQ.rd) else $error("chained fetch");
  a_idle_quiet: assert property (!BUSY |-> !MEM_REQ.rd && !MEM_REQ.wr) else $error("access while idle");
  a_fault_clear: assert property (REG_WR && REG_ADDR == ADDR_CONTROL && !REG_WDATA[CC_FAULT] && !BUSY
    |-> ##2 !ERR_IRQ) else $error("error request stays");
  c_start: cover property ($rose(BUSY));
  c_rx_vector: cover property (vec_rd && MEM_REQ.addr == vbase + VEC_OFS_RX);
  c_end_irq: cover property (CPU_IRQ);
  c_fault: cover property ($rose(ERR_IRQ));
endmodule // ettx_properties
bind ettx_engine ettx_properties chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .TX_EMPTY_REQUEST(TX_EMPTY_REQUEST), .RX_FULL_REQUEST(RX_FULL_REQUEST), .MEM_REQ(MEM_REQ),
  .MEM_RDATA(MEM_RDATA), .CPU_IRQ(CPU_IRQ), .ERR_IRQ(ERR_IRQ), .BUSY(BUSY));

// [verification/ettx_far_model.sv]
// Purpose: Memory and serial port at the far side of the engine.
// Assumes: Reads answer inside the request cycle, writes land at once.
// Notes: Unwritten words read as the inverse of their address.
`timescale 1ns/1ps
module ettx_far_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Memory slave.
  input wire ettx_pkg::ettx_mem_req_type mem_req,
  output logic [31:0] mem_rdata,
  // Serial port.
  input wire logic tx_on,
  input wire logic rx_on,
  output logic tx_empty_request,
  output logic rx_full_request
);
  import ettx_pkg::*;
  localparam logic [31:0] TX_HOLD = 32'h00f00003;
  localparam logic [31:0] RX_HOLD = 32'h00f00005;
  logic [31:0] mem [logic [31:0]];
  logic [7:0] tx_log [$];
  logic [31:0] wa;
  logic [31:0] w;
  logic [7:0] status;
  logic [7:0] rx_next;
  logic [3:0] gap;
  logic slow;
  logic rx_taken;
  logic tx_write;
  assign wa = {mem_req.addr[31:2], 2'b00};
  assign tx_write = mem_req.wr && wa == {TX_HOLD[31:2], 2'b00} && mem_req.be[3 - TX_HOLD[1:0]];
  // Read data settle at the falling edge of the request cycle; the engine takes them at the next rising edge.
  always @(negedge clk_sys) begin
    mem_rdata <= !rst_n ? 32'h0 : mem_req.rd ? (mem.exists(wa) ? mem[wa] : ~wa) : ~mem_rdata;
  end
  always @(posedge clk_sys) begin
    if (mem_req.wr) begin
      w = mem.exists(wa) ? mem[wa] : 32'h0;
      for (int b = 0; b < 4; b++) begin
        if (mem_req.be[3-b]) w[31-8*b -: 8] = mem_req.wdata[31-8*b -: 8];
      end
      mem[wa] = w;
    end
  end
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      status <= 8'h84;
      tx_empty_request <= 1'b0;
      rx_full_request <= 1'b0;
      rx_next <= 8'ha0;
      gap <= 4'h0;
      slow <= 1'b0;
      rx_taken <= 1'b0;
    end else begin
      rx_taken <= mem_req.rd && wa == {RX_HOLD[31:2], 2'b00};
      if (gap != 4'h0) gap <= gap - 4'h1;
      else status[7] <= 1'b1;
      tx_empty_request <= tx_on && status[7] && !tx_write;
      if (tx_write) begin
        tx_log.push_back(mem_req.wdata[7:0]);
        status[7] <= 1'b0;
        gap <= slow ? 4'h7 : 4'h1;
        slow <= !slow;
      end
      if (rx_taken) begin
        rx_full_request <= 1'b0;
        rx_next <= rx_next + 8'h01;
        gap <= 4'h3;
      end else if (rx_on && !rx_full_request && gap == 4'h0) begin
        mem[{RX_HOLD[31:2], 2'b00}] = {8'h00, rx_next, 16'h0000};
        rx_full_request <= 1'b1;
      end
    end
  end
endmodule // ettx_far_model

// [verification/event_triggered_transfer_engine_test.sv]
// Purpose: Self-checking bench of the transfer engine with serial traffic.
// Assumes: Vector table and records live in the far model memory.
// Notes: Each scenario is a task that judges its own outcome.
`timescale 1ns/1ps
module event_triggered_transfer_engine_test;
  import ettx_pkg::*;
  localparam logic [31:0] VBASE = 32'hfff86000;
  localparam logic [31:0] TX_HOLD = 32'h00f00003;
  localparam logic [31:0] RX_HOLD = 32'h00f00005;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic tx_req;
  logic rx_req;
  ettx_mem_req_type mem_req;
  logic [31:0] mem_rdata;
  logic cpu_irq;
  logic err_irq;
  logic busy;
  logic tx_on = 1'b0;
  logic rx_on = 1'b0;
  logic [31:0] rd_val;
  int err_total = 0;
  int compares = 0;
  always #25 clk_sys = ~clk_sys;
  ettx_engine dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .TX_EMPTY_REQUEST(tx_req),
    .RX_FULL_REQUEST(rx_req), .MEM_REQ(mem_req), .MEM_RDATA(mem_rdata), .CPU_IRQ(cpu_irq),
    .ERR_IRQ(err_irq), .BUSY(busy));
  ettx_far_model far (.clk_sys(clk_sys), .rst_n(rst_n), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .tx_on(tx_on), .rx_on(rx_on), .tx_empty_request(tx_req), .rx_full_request(rx_req));
  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic bus_write(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic bus_read(input logic [31:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic wait_irq();
    int t;
    t = 0;
    while (t < 4000) begin
      @(posedge clk_sys);
      t = (cpu_irq === 1'b1) ? 5000 : t + 1;
    end
    chk(t, 5000);
  endtask
  task automatic test_regs();
    bus_read(ADDR_ENABLE_E);
    chk(rd_val, 32'h0);
    bus_read(ADDR_CONTROL);
    chk(rd_val, 32'h0);
    bus_write(ADDR_VECTOR_BASE, VBASE);
    bus_write(32'hfffe600c, 32'hffffffff);
    bus_read(32'hfffe600c);
    chk(rd_val, 32'h0);
    bus_read(ADDR_VECTOR_BASE);
    chk(rd_val, VBASE);
  endtask
  task automatic test_disabled();
    @(posedge clk_sys);
    tx_on <= 1'b1;
    repeat (30) @(posedge clk_sys);
    chk(busy, 1'b0);
    chk(far.tx_log.size(), 0);
  endtask
  task automatic test_tx();
    far.mem[VBASE] = 32'hfff80000;
    far.mem[VBASE + 4] = 32'hfff80010;
    far.mem[32'hfff80000] = 32'h08000000;
    far.mem[32'hfff80004] = 32'hfff80100;
    far.mem[32'hfff80008] = TX_HOLD;
    far.mem[32'hfff8000c] = 32'h00200000;
    for (int i = 0; i < 8; i++) far.mem[32'hfff80100 + 4 * i] = 32'h30313233 + 32'h04040404 * i;
    bus_write(ADDR_ENABLE_E, 32'h00000400);
    wait_irq();
    chk(far.tx_log.size(), 32);
    for (int i = 0; i < 32; i++) chk(far.tx_log[i], 8'h30 + i);
    chk(far.mem[32'hfff80004], 32'hfff80120);
    chk(far.mem[32'hfff80008], TX_HOLD);
    chk(far.mem[32'hfff8000c], 32'h0);
    bus_read(ADDR_ENABLE_E);
    chk(rd_val, 32'h0);
  endtask
  task automatic test_rx();
    far.mem[32'hfff80010] = 32'h00080000;
    far.mem[32'hfff80014] = RX_HOLD;
    far.mem[32'hfff80018] = 32'hfff80200;
    far.mem[32'hfff8001c] = 32'h00010000;
    far.mem[32'hfff80200] = 32'h55555555;
    bus_write(ADDR_ENABLE_E, 32'h00000800);
    rx_on <= 1'b1;
    wait_irq();
    chk(far.mem[32'hfff80200], 32'ha0555555);
    chk(far.mem[32'hfff80014], RX_HOLD);
    chk(far.mem[32'hfff80018], 32'hfff80201);
    chk(far.mem[32'hfff8001c], 32'h0);
  endtask
  task automatic test_fault();
    rx_on <= 1'b0;
    far.mem[VBASE] = 32'hfff80020;
    far.mem[32'hfff80020] = 32'hc0000000;
    bus_write(ADDR_ENABLE_E, 32'h00000400);
    repeat (40) @(posedge clk_sys);
    bus_read(ADDR_CONTROL);
    chk(rd_val[CC_FAULT], 1'b1);
    chk(err_irq, 1'b1);
    chk(far.tx_log.size(), 32);
    bus_write(ADDR_ENABLE_E, 32'h0);
    repeat (30) @(posedge clk_sys);
    bus_write(ADDR_CONTROL, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk(err_irq, 1'b0);
  endtask
  initial begin
    #(50 * 20000);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_regs();
    test_disabled();
    test_tx();
    test_rx();
    test_fault();
    end_of_test();
  end
endmodule // event_triggered_transfer_engine_test
